// *** rtl/jtag_tap_register_set.sv ***
`timescale 1ns/1ps
module jtag_tap_register_set #(
   parameter int unsigned BSR_LEN   = tap_pkg::BSR_LEN_MIN,  // chain length of this variant
   parameter int unsigned IO_W      = 8,                     // device pins under test
   parameter logic [31:0] USER_CODE = tap_pkg::UCODE_RST     // programmed user code
) (
   input  wire logic            clk_sys,      // 125 MHz system clock
   input  wire logic            rstn,         // synchronous, active low
   input  wire logic            tck,          // test clock pin, sampled
   input  wire logic            tms,          // mode select pin
   input  wire logic            tdi,          // serial data in pin
   output logic                 tdo,          // serial data out
   output logic                 tdo_oe,       // high while tdo is driven
   input  wire logic            cfg_busy,     // configuration in progress
   input  wire logic [IO_W-1:0] pin_in,       // input pin states
   input  wire logic [IO_W-1:0] core_out,     // core values for output pins
   output logic      [IO_W-1:0] pin_out,      // value driven to output pins
   output logic                 analyzer_sel  // analyzer instruction active
);
   // storage floor: the scanless variant keeps io-wide cells that are never selected,
   // so the pin capture and update slices stay in range; assumes BSR_LEN >= IO_W when >1
   localparam int unsigned CELL_W = (BSR_LEN > IO_W) ? BSR_LEN : IO_W;
   localparam bit          SCAN_OK = (BSR_LEN > tap_pkg::BSR_LEN_NONE);

   logic [2:0]      pins_s;        // synchronised tck, tms, tdi
   logic [IO_W-1:0] pin_in_s;      // synchronised input pins
   logic            tck_q;         // previous sampled tck
   logic            cfg_s;         // synchronised configuration busy
   tap_pkg::tap_state_t state;     // controller state
   tap_pkg::tap_state_t next_state;
   logic [9:0]      ir_sh;         // instruction shift stage
   logic [9:0]      ir;            // active instruction
   logic [31:0]     dr_sh;         // shared stage for id, user code
   logic            byp;           // one bit bypass register
   logic [CELL_W-1:0] bsr_sh;      // boundary shift cells
   logic [IO_W-1:0] bsr_upd;       // boundary update latches

   pin_sync #(.W(3)) u_sync_jtag (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .din     ({tck, tms, tdi}),
      .dout    (pins_s)
   );
   pin_sync #(.W(IO_W + 1)) u_sync_io (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .din     ({cfg_busy, pin_in}),
      .dout    ({cfg_s, pin_in_s})
   );

   wire tck_s = pins_s[2];
   wire tms_s = pins_s[1];
   wire tdi_s = pins_s[0];
   wire rise  = tck_s & ~tck_q;   // shift and state advance on rising tck
   wire fall  = ~tck_s & tck_q;   // tdo changes on falling tck

   // instruction decode; unknown codes fall back to bypass
   wire sel_id   = (ir == tap_pkg::OP_IDCODE);
   wire sel_uc   = (ir == tap_pkg::OP_UCODE);
   // scan instructions exist only on variants with a chain, and idle in configuration
   wire scan_ins = (ir == tap_pkg::OP_EXTEST) | (ir == tap_pkg::OP_SAMPLE);
   wire sel_bsr  = scan_ins & SCAN_OK & ~cfg_s;
   wire sel_ext  = (ir == tap_pkg::OP_EXTEST) & sel_bsr;
   wire sel_byp  = ~(sel_id | sel_uc | sel_bsr);

   // identity word, fixed one at bit zero
   wire [31:0] id_word = {tap_pkg::ID_VER_RST, tap_pkg::ID_PART_RST,
                          tap_pkg::ID_MFR_RST, 1'b1};

   // capture value for the boundary chain: input pin states in the low cells
   logic [CELL_W-1:0] bsr_cap;
   always_comb
   begin
      bsr_cap = '0;
      bsr_cap[IO_W-1:0] = pin_in_s;
   end

   // next controller state from tms on each rising tck
   always_comb
   begin
      case (state)
         tap_pkg::ST_RESET:  next_state = tms_s ? tap_pkg::ST_RESET  : tap_pkg::ST_IDLE;
         tap_pkg::ST_IDLE:   next_state = tms_s ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         tap_pkg::ST_SEL_DR: next_state = tms_s ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
         tap_pkg::ST_CAP_DR: next_state = tms_s ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
         tap_pkg::ST_SH_DR:  next_state = tms_s ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
         tap_pkg::ST_EX1_DR: next_state = tms_s ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PA_DR;
         tap_pkg::ST_PA_DR:  next_state = tms_s ? tap_pkg::ST_EX2_DR : tap_pkg::ST_PA_DR;
         tap_pkg::ST_EX2_DR: next_state = tms_s ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SH_DR;
         tap_pkg::ST_UPD_DR: next_state = tms_s ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         tap_pkg::ST_SEL_IR: next_state = tms_s ? tap_pkg::ST_RESET  : tap_pkg::ST_CAP_IR;
         tap_pkg::ST_CAP_IR: next_state = tms_s ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
         tap_pkg::ST_SH_IR:  next_state = tms_s ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
         tap_pkg::ST_EX1_IR: next_state = tms_s ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PA_IR;
         tap_pkg::ST_PA_IR:  next_state = tms_s ? tap_pkg::ST_EX2_IR : tap_pkg::ST_PA_IR;
         tap_pkg::ST_EX2_IR: next_state = tms_s ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SH_IR;
         default:            next_state = tms_s ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
      endcase
   end

   // state and tck edge tracking
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         tck_q <= 1'b0;
         state <= tap_pkg::ST_RESET;
      end
      else
      begin
         tck_q <= tck_s;
         if (rise)
            state <= next_state;
      end
   end

   // instruction register: ten bit shift, load on update
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         ir_sh <= tap_pkg::IR_CAPTURE;
         ir    <= tap_pkg::OP_IDCODE;
      end
      else if (rise)
      begin
         if (state == tap_pkg::ST_RESET)
            ir <= tap_pkg::OP_IDCODE;               // identity selected after reset
         else if (state == tap_pkg::ST_CAP_IR)
            ir_sh <= tap_pkg::IR_CAPTURE;
         else if (state == tap_pkg::ST_SH_IR)
            ir_sh <= {tdi_s, ir_sh[9:1]};
         else if (state == tap_pkg::ST_UPD_IR)
            ir <= ir_sh;
      end
   end

   // identity / user code stage and bypass bit
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         dr_sh <= '0;
         byp   <= 1'b0;
      end
      else if (rise)
      begin
         if (state == tap_pkg::ST_CAP_DR)
         begin
            dr_sh <= sel_uc ? USER_CODE : id_word;
            byp   <= 1'b0;
         end
         else if (state == tap_pkg::ST_SH_DR)
         begin
            dr_sh <= {tdi_s, dr_sh[31:1]};
            byp   <= tdi_s;
         end
      end
   end

   // boundary chain: capture pins, shift lsb first, update drives outputs under extest
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         bsr_sh  <= '0;
         bsr_upd <= '0;
      end
      else if (rise && sel_bsr)
      begin
         if (state == tap_pkg::ST_CAP_DR)
            bsr_sh <= bsr_cap;
         else if (state == tap_pkg::ST_SH_DR)
            bsr_sh <= {tdi_s, bsr_sh[CELL_W-1:1]};
         else if (state == tap_pkg::ST_UPD_DR)
            bsr_upd <= bsr_sh[IO_W-1:0];
      end
   end

   // serial output selection
   wire tdo_bit = (state == tap_pkg::ST_SH_IR) ? ir_sh[0] :
                  sel_bsr ? bsr_sh[0] :
                  (sel_id | sel_uc) ? dr_sh[0] : byp;

   // tdo updates on falling tck, driven only while shifting
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end
      else if (fall)
      begin
         tdo    <= tdo_bit;
         tdo_oe <= (state == tap_pkg::ST_SH_IR) | (state == tap_pkg::ST_SH_DR);
      end
   end

   // pins follow the core unless external test holds them
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         pin_out <= '0;
      else
         pin_out <= sel_ext ? bsr_upd : core_out;
   end

   // analyzer instruction passes through on every variant
   assign analyzer_sel = (ir == tap_pkg::OP_ANALYZER);

   // checks
   property p_id_lsb;
      @(posedge clk_sys) disable iff (!rstn)
      (rise && state == tap_pkg::ST_CAP_DR && sel_id) |=> dr_sh[0];
   endproperty
   a_id_lsb: assert property (p_id_lsb) else $error("id lsb not one");

   property p_id_fields;
      @(posedge clk_sys) disable iff (!rstn)
      (rise && state == tap_pkg::ST_CAP_DR && sel_id) |=> dr_sh == id_word;
   endproperty
   a_id_fields: assert property (p_id_fields) else $error("id layout wrong");

   property p_uc_cap;
      @(posedge clk_sys) disable iff (!rstn)
      (rise && state == tap_pkg::ST_CAP_DR && sel_uc) |=> dr_sh == USER_CODE;
   endproperty
   a_uc_cap: assert property (p_uc_cap) else $error("user code not captured");

   property p_ir_load;
      @(posedge clk_sys) disable iff (!rstn)
      (rise && state == tap_pkg::ST_UPD_IR) |=> ir == $past(ir_sh);
   endproperty
   a_ir_load: assert property (p_ir_load) else $error("ir not loaded");

   property p_byp_shift;
      @(posedge clk_sys) disable iff (!rstn)
      (rise && state == tap_pkg::ST_SH_DR) |=> byp == $past(tdi_s);
   endproperty
   a_byp_shift: assert property (p_byp_shift) else $error("bypass bit wrong");

   property p_dr_lsb_first;
      @(posedge clk_sys) disable iff (!rstn)
      (rise && state == tap_pkg::ST_SH_DR) |=> dr_sh[30:0] == $past(dr_sh[31:1]);
   endproperty
   a_dr_lsb_first: assert property (p_dr_lsb_first) else $error("shift order");

   property p_no_scan_cfg;
      @(posedge clk_sys) disable iff (!rstn)
      cfg_s |=> pin_out == $past(core_out) && $stable(bsr_upd);
   endproperty
   a_no_scan_cfg: assert property (p_no_scan_cfg) else $error("scan in config");

   property p_ext_drive;
      @(posedge clk_sys) disable iff (!rstn)
      sel_ext ##1 sel_ext |-> pin_out == $past(bsr_upd);
   endproperty
   a_ext_drive: assert property (p_ext_drive) else $error("extest pins wrong");

   property p_scanless;
      @(posedge clk_sys) disable iff (!rstn)
      !SCAN_OK |=> pin_out == $past(core_out);
   endproperty
   a_scanless: assert property (p_scanless) else $error("scanless scan");
endmodule // jtag_tap_register_set

// *** pkg/tap_pkg.sv ***
package tap_pkg;
   // instruction register width
   localparam int unsigned IR_W         = 10;
   // user code and identification register widths
   localparam int unsigned UCODE_W      = 32;
   localparam int unsigned ID_W         = 32;
   // identification field positions, msb down to the fixed one
   localparam int unsigned ID_VER_LSB   = 28;
   localparam int unsigned ID_PART_LSB  = 12;
   localparam int unsigned ID_MFR_LSB   = 1;
   localparam int unsigned ID_VER_W     = 4;
   localparam int unsigned ID_PART_W    = 16;
   localparam int unsigned ID_MFR_W     = 11;
   // boundary chain lengths: smallest, largest, and the variant without scan
   localparam int unsigned BSR_LEN_MIN  = 420;
   localparam int unsigned BSR_LEN_MAX  = 2190;
   localparam int unsigned BSR_LEN_NONE = 1;
   // instruction codes (chosen; all ones is bypass by convention)
   localparam logic [9:0] OP_EXTEST   = 10'h000;
   localparam logic [9:0] OP_SAMPLE   = 10'h005;
   localparam logic [9:0] OP_IDCODE   = 10'h006;
   localparam logic [9:0] OP_UCODE    = 10'h007;
   localparam logic [9:0] OP_ANALYZER = 10'h00E;
   localparam logic [9:0] OP_BYPASS   = 10'h3FF;
   // capture pattern of the instruction register: 01 in the low bits
   localparam logic [9:0] IR_CAPTURE  = 10'h001;
   // reset values of the identity fields (arbitrary, neutral)
   localparam logic [3:0]  ID_VER_RST  = 4'h1;
   localparam logic [15:0] ID_PART_RST = 16'h1234;
   localparam logic [10:0] ID_MFR_RST  = 11'h055;
   localparam logic [31:0] UCODE_RST   = 32'h0000_0000;
   // controller states of the test access port
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR,
      ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
      ST_PA_IR, ST_EX2_IR, ST_UPD_IR
   } tap_state_t;
endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
// two flop synchroniser for a group of pin inputs
module pin_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rstn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] stage1;   // only read by the second stage
   // first flop is metastability catcher; nothing else looks at it
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         stage1 <= '0;
         dout   <= '0;
      end
      else
      begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule // pin_sync

// *** tb/tap_ctrl_model.sv ***
`timescale 1ns/1ps
// behavioural boundary-scan controller; the test clock rests low between frames
module tap_ctrl_model (
   output logic      tck,  // test clock, 160 ns period while a frame runs
   output logic      tms,  // mode select
   output logic      tdi,  // serial data towards the device
   input  wire logic tdo   // serial data from the device
);
   logic last_tdi;  // last bit sent; a released data line shows its inverse
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      last_tdi = 1'b0;
   end
   // one test clock period; tdo is taken just before the rising edge
   // both tck edges sit 2 ns off a system clock edge so the synchroniser never races
   task automatic tick(input logic m, input logic d, output logic q);
      #3;
      tms = m;
      tdi = d;
      last_tdi = d;
      #75;
      q = tdo;
      tck = 1'b1;
      #80;
      tck = 1'b0;
      #2;
   endtask
   // a period outside shift states: data line carries no stale value
   task automatic step(input logic m);
      logic q;
      tick(m, ~last_tdi, q);
   endtask
   // five periods with tms high always reach reset, then park in idle
   task automatic reset_tap();
      repeat (5) step(1'b1);
      step(1'b0);
   endtask
   // from idle: one instruction or data scan of n bits, back to idle
   task automatic scan(input logic ir, input int n, input logic [511:0] din,
                       output logic [511:0] dout);
      logic q;
      dout = '0;
      step(1'b1);
      if (ir)
      begin
         step(1'b1);
      end
      step(1'b0);
      step(1'b0);
      for (int i = 0; i < n; i++)
      begin
         tick(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1);
      step(1'b0);
   endtask
endmodule // tap_ctrl_model

// *** tb/jtag_tap_register_set_tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module jtag_tap_register_set_tb;
   localparam logic [31:0] UCODE = 32'hC0DE_5A01;          // programmed user code
   localparam int unsigned BLEN  = tap_pkg::BSR_LEN_MIN;   // smallest chain variant
   localparam logic [31:0] ID_EXP = {tap_pkg::ID_VER_RST, tap_pkg::ID_PART_RST,
                                     tap_pkg::ID_MFR_RST, 1'b1};
   logic         clk_sys  = 1'b0;
   logic         rstn     = 1'b0;
   logic         cfg_busy = 1'b0;
   logic [7:0]   pin_in   = 8'h00;
   logic [7:0]   core_out = 8'h00;
   logic         tck_a, tms_a, tdi_a, tdo_a, oe_a, an_a;  // full scan variant
   logic         tck_b, tms_b, tdi_b, tdo_b, oe_b, an_b;  // scanless variant
   logic [7:0]   pout_a, pout_b;
   logic [511:0] so;                                    // bits scanned out
   int           n_fail    = 0;
   int           cmp_count = 0;
   int           oe_rises  = 0;                         // tck rises seen with tdo driven
   always #4 clk_sys = ~clk_sys;
   // count shift cycles by the output enable seen at each rising test clock
   always @(posedge tck_a or posedge tck_b)
      oe_rises <= oe_rises + int'(oe_a === 1'b1) + int'(oe_b === 1'b1);
   jtag_tap_register_set #(.BSR_LEN(BLEN), .IO_W(8), .USER_CODE(UCODE)) i_jtag_tap_register_set (
      .clk_sys(clk_sys), .rstn(rstn), .tck(tck_a), .tms(tms_a), .tdi(tdi_a), .tdo(tdo_a),
      .tdo_oe(oe_a), .cfg_busy(cfg_busy), .pin_in(pin_in), .core_out(core_out),
      .pin_out(pout_a), .analyzer_sel(an_a));
   // second instance name departs from house naming: two of one module
   jtag_tap_register_set #(.BSR_LEN(tap_pkg::BSR_LEN_NONE), .IO_W(8), .USER_CODE(UCODE))
   i_jtag_tap_register_set_nb (
      .clk_sys(clk_sys), .rstn(rstn), .tck(tck_b), .tms(tms_b), .tdi(tdi_b), .tdo(tdo_b),
      .tdo_oe(oe_b), .cfg_busy(cfg_busy), .pin_in(pin_in), .core_out(core_out),
      .pin_out(pout_b), .analyzer_sel(an_b));
   tap_ctrl_model i_tap_ctrl_model (.tck(tck_a), .tms(tms_a), .tdi(tdi_a), .tdo(tdo_a));
   tap_ctrl_model i_tap_ctrl_model_nb (.tck(tck_b), .tms(tms_b), .tdi(tdi_b), .tdo(tdo_b));
   // instruction load, always exactly ten bits; checks the capture pattern
   task automatic ir(input bit b, input logic [9:0] code);
      logic [511:0] q;
      if (b)
         i_tap_ctrl_model_nb.scan(1'b1, tap_pkg::IR_W, 512'(code), q);
      else
         i_tap_ctrl_model.scan(1'b1, tap_pkg::IR_W, 512'(code), q);
      `CHK("ir capture", tap_pkg::IR_CAPTURE, q[9:0])
   endtask
   // data scan of n bits into the selected register
   task automatic dr(input bit b, input int n, input logic [511:0] d);
      if (b)
         i_tap_ctrl_model_nb.scan(1'b0, n, d, so);
      else
         i_tap_ctrl_model.scan(1'b0, n, d, so);
   endtask
   task automatic t_idcode();
      int n0;
      i_tap_ctrl_model.reset_tap();
      n0 = oe_rises;
      dr(0, 32, 512'h0);
      `CHK("idcode", ID_EXP, so[31:0])
      `CHK("oe shift cycles", 32, oe_rises - n0)
      `CHK("analyzer idle", 1'b0, an_a)
      `CHK("id first bit", 1'b1, so[0])
      i_tap_ctrl_model_nb.reset_tap();
      dr(1, 32, 512'h0);
      `CHK("id lsb scanless", 1'b1, so[0])
      $display("test idcode done");
   endtask
   // 64 shifts: code first, then the pattern sent in proves a 32 bit path
   task automatic t_ucode();
      ir(0, tap_pkg::OP_UCODE);
      dr(0, 64, 512'(32'h1357_9BDF));
      `CHK("user code", UCODE, so[31:0])
      `CHK("user code length", 32'h1357_9BDF, so[63:32])
      $display("test user code done");
   endtask
   // both the bypass code and an unknown code give a one bit path
   task automatic t_bypass();
      logic [9:0] codes[2];
      codes = '{tap_pkg::OP_BYPASS, 10'h155};
      foreach (codes[k])
      begin
         i_tap_ctrl_model.reset_tap();
         ir(0, codes[k]);
         dr(0, 8, 512'(8'hB4));
         `CHK("bypass", 8'h68, so[7:0])
      end
      $display("test bypass done");
   endtask
   // preload through sample, then external test drives the preloaded cells
   task automatic t_boundary();
      @(posedge clk_sys);
      pin_in <= 8'hA5;
      core_out <= 8'h5A;
      i_tap_ctrl_model.reset_tap();
      `CHK("normal pins", 8'h5A, pout_a)
      ir(0, tap_pkg::OP_SAMPLE);
      dr(0, BLEN + 8, 512'(16'h3CC3));
      `CHK("captured pins", 8'hA5, so[7:0])
      `CHK("chain length", 8'hC3, so[BLEN +: 8])
      ir(0, tap_pkg::OP_EXTEST);
      `CHK("extest drive", 8'h3C, pout_a)
      i_tap_ctrl_model.reset_tap();
      `CHK("pins released", 8'h5A, pout_a)
      $display("test boundary done");
   endtask
   // scan selection during configuration must fall back to bypass
   task automatic t_cfg();
      @(posedge clk_sys);
      cfg_busy <= 1'b1;
      i_tap_ctrl_model.reset_tap();
      ir(0, tap_pkg::OP_EXTEST);
      dr(0, 4, 512'(4'hB));
      `CHK("busy bypass", 4'h6, so[3:0])
      `CHK("busy pins", 8'h5A, pout_a)
      @(posedge clk_sys);
      cfg_busy <= 1'b0;
      repeat (4) @(posedge clk_sys);
      `CHK("scan after config", 8'h3C, pout_a)
      $display("test configuration done");
   endtask
   task automatic t_scanless();
      int n0;
      i_tap_ctrl_model_nb.reset_tap();
      ir(1, tap_pkg::OP_EXTEST);
      `CHK("scanless pins", 8'h5A, pout_b)
      dr(1, 4, 512'(4'hB));
      `CHK("scanless chain", 4'h6, so[3:0])
      ir(1, tap_pkg::OP_ANALYZER);
      `CHK("analyzer on", 1'b1, an_b)
      ir(1, tap_pkg::OP_BYPASS);
      `CHK("analyzer off", 1'b0, an_b)
      n0 = oe_rises;
      dr(1, 8, 512'(8'hB4));
      `CHK("scanless bypass", 8'h68, so[7:0])
      `CHK("scanless oe cycles", 8, oe_rises - n0)
      $display("test scanless done");
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // main sequence: reset held for ten cycles, then the scenarios
   initial
   begin
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_idcode();
      t_ucode();
      t_bypass();
      t_boundary();
      t_cfg();
      t_scanless();
      end_sim();
   end
   // watchdog: the scans need about 130 us, so 600 us means a hang
   initial
   begin
      #600_000;
      n_fail++;
      $display("[FAIL] watchdog expired");
      end_sim();
   end
endmodule // jtag_tap_register_set_tb
